// File: rtl/sarp_dev.sv
// converter end: conversion sequencer, result latch, reset and powerdown
`default_nettype none

module sarp_dev (
   input wire logic mclk,
   input wire logic rst,
   sarp_if.dev bus,
   input wire logic [11:0] analog_in,
   output logic inputs_isolated,
   output logic powered_down,
   output logic initialising
);
   typedef struct packed {
      sarp_pkg::sarp_dstate_t st;
      logic cnv_n_prev;
      logic cs_n_prev;
      logic [3:0] step;
      logic [3:0] bit_idx;
      logic [11:0] sar;
      logic [11:0] hold;
      logic [11:0] result;
      logic marker;
      logic [2:0] init_cnt;
      logic [9:0] tmr;
      logic busy;
      logic isolated;
      logic pd;
      logic oe;
      logic [11:0] data;
      logic init_flag;
   } sarp_dev_t;

   sarp_dev_t q, d;
   logic cnv_fall;
   logic cs_fall;
   logic [11:0] trial;
   logic [11:0] sar_next;

   // =====================================
   // next state
   always_comb
   begin
      d = q;
      d.cnv_n_prev = bus.conversion_start_n;
      d.cs_n_prev = bus.cs_n;
      cnv_fall = q.cnv_n_prev & ~bus.conversion_start_n;
      cs_fall = q.cs_n_prev & ~bus.cs_n;
      // successive approximation trial against held sample
      trial = q.sar | (12'h0001 << q.bit_idx);
      sar_next = (trial <= q.hold) ? trial : q.sar;
      if (!bus.powerdown_reset_n && (q.st != sarp_pkg::DS_RST) && (q.st != sarp_pkg::DS_PWRDN))
      begin
         // abandon any conversion next edge
         d.st = sarp_pkg::DS_RST;
         d.tmr = 10'h000;
         d.busy = 1'b0;
         d.isolated = 1'b0;
         d.marker = 1'b1;
         d.init_cnt = sarp_pkg::INIT_CONV;
      end
      else
      begin
         unique case (q.st)
            sarp_pkg::DS_ACQ:
            begin
               if (cnv_fall)
               begin
                  d.st = sarp_pkg::DS_CONV;
                  d.hold = analog_in;
                  d.isolated = 1'b1;
                  d.busy = 1'b1;
                  d.sar = 12'h0000;
                  d.bit_idx = 4'(sarp_pkg::DATA_W - 1);
                  d.step = 4'h0;
               end
            end
            sarp_pkg::DS_CONV:
            begin
               if (cs_fall && bus.conversion_start_n)
               begin
                  d.st = sarp_pkg::DS_ACQ;
                  d.busy = 1'b0;
                  d.isolated = 1'b0;
                  d.marker = 1'b1;
               end
               else if (q.step == 4'(sarp_pkg::STEP_CYC - 1))
               begin
                  // internal conversion clock tick
                  d.step = 4'h0;
                  d.sar = sar_next;
                  if (q.bit_idx == 4'h0)
                  begin
                     d.st = sarp_pkg::DS_ACQ;
                     d.result = sar_next;
                     d.marker = 1'b0;
                     d.busy = 1'b0;
                     d.isolated = 1'b0;
                     if (q.init_cnt != 3'h0)
                     begin
                        d.init_cnt = q.init_cnt - 3'h1;
                     end
                  end
                  else
                  begin
                     d.bit_idx = q.bit_idx - 4'h1;
                  end
               end
               else
               begin
                  d.step = q.step + 4'h1;
               end
            end
            sarp_pkg::DS_RST:
            begin
               if (bus.powerdown_reset_n)
               begin
                  d.st = sarp_pkg::DS_ACQ;
               end
               else if (q.tmr == 10'(sarp_pkg::PWRDN_CYC - 1))
               begin
                  d.st = sarp_pkg::DS_PWRDN;
                  d.pd = 1'b1;
               end
               else
               begin
                  d.tmr = q.tmr + 10'h001;
               end
            end
            sarp_pkg::DS_PWRDN:
            begin
               if (bus.powerdown_reset_n)
               begin
                  d.st = sarp_pkg::DS_WAKE;
                  d.tmr = 10'h000;
               end
            end
            sarp_pkg::DS_WAKE:
            begin
               if (q.tmr == 10'(sarp_pkg::WAKE_CYC - 1))
               begin
                  d.st = sarp_pkg::DS_ACQ;
                  d.pd = 1'b0;
               end
               else
               begin
                  d.tmr = q.tmr + 10'h001;
               end
            end
            default:
            begin
               d.st = sarp_pkg::DS_ACQ;
            end
         endcase
      end
      // output drive and format
      d.oe = ~bus.cs_n & ~bus.rd_n;
      if (d.marker)
      begin
         d.data = sarp_pkg::MARKER_CODE;
      end
      else if (bus.byte_sel)
      begin
         d.data = {d.result[3:0], 8'h00};
      end
      else
      begin
         d.data = d.result;
      end
      // start-up flag registered so the output comes from a flop
      d.init_flag = (d.init_cnt != 3'h0);
   end

   // =====================================
   // state register
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         q <= '{st: sarp_pkg::DS_ACQ, cnv_n_prev: 1'b1, cs_n_prev: 1'b1, step: 4'h0, bit_idx: 4'h0,
                sar: 12'h0000, hold: 12'h0000, result: sarp_pkg::RESULT_RST, marker: 1'b0,
                init_cnt: sarp_pkg::INIT_CONV, tmr: 10'h000, busy: 1'b0, isolated: 1'b0, pd: 1'b0,
                oe: 1'b0, data: sarp_pkg::RESULT_RST, init_flag: 1'b1};
      end
      else
      begin
         q <= d;
      end
   end

   // =====================================
   // outputs straight from flops
   assign bus.busy = q.busy;
   assign bus.data_out = q.data;
   assign bus.data_oe = q.oe;
   assign inputs_isolated = q.isolated;
   assign powered_down = q.pd;
   assign initialising = q.init_flag;
endmodule : sarp_dev

`default_nettype wire

// File: rtl/sarp_host.sv
// host end: start, busy wait, one or two part read, reset and powerdown control
`default_nettype none

module sarp_host (
   input wire logic mclk,
   input wire logic rst,
   sarp_if.host bus,
   input wire logic start,
   input wire logic byte_mode,
   input wire logic keep_rd_low,
   input wire logic pd_req,
   output logic ready,
   output logic [11:0] result,
   output logic result_valid,
   output logic conv_error
);
   typedef struct packed {
      sarp_pkg::sarp_hstate_t st;
      logic [9:0] tmr;
      logic cnv_n;
      logic cs_n;
      logic rd_n;
      logic byte_sel;
      logic pdr_n;
      logic [2:0] discard;
      logic [11:0] result;
      logic valid;
      logic err;
      logic ready;
   } sarp_host_t;

   sarp_host_t q, d;

   // =====================================
   // next state
   always_comb
   begin
      d = q;
      d.valid = 1'b0;
      d.err = 1'b0;
      d.ready = 1'b0;
      d.tmr = q.tmr + 10'h001;
      unique case (q.st)
         sarp_pkg::HS_RST:
         begin
            d.pdr_n = 1'b0;
            if (q.tmr == 10'(sarp_pkg::RST_PULSE_CYC - 1))
            begin
               d.pdr_n = 1'b1;
               d.discard = sarp_pkg::INIT_CONV;
               d.st = sarp_pkg::HS_IDLE;
               d.ready = 1'b1;
            end
         end
         sarp_pkg::HS_IDLE:
         begin
            d.ready = 1'b1;
            if (pd_req)
            begin
               d.pdr_n = 1'b0;
               d.tmr = 10'h000;
               d.ready = 1'b0;
               d.st = sarp_pkg::HS_PD;
            end
            else if (start)
            begin
               // start edge with select and read high
               d.cnv_n = 1'b0;
               d.tmr = 10'h000;
               d.ready = 1'b0;
               d.st = sarp_pkg::HS_CNV;
            end
         end
         sarp_pkg::HS_CNV:
         begin
            if (bus.busy && (q.tmr >= 10'(sarp_pkg::CNV_LOW_CYC - 1)))
            begin
               d.cnv_n = 1'b1;
               d.tmr = 10'h000;
               d.st = sarp_pkg::HS_BUSY;
            end
            else if (q.tmr == 10'(sarp_pkg::BUSY_WAIT_CYC - 1))
            begin
               d.cnv_n = 1'b1;
               d.err = 1'b1;
               d.st = sarp_pkg::HS_IDLE;
            end
         end
         sarp_pkg::HS_BUSY:
         begin
            if (!bus.busy)
            begin
               d.cs_n = 1'b0;
               d.rd_n = 1'b0;
               d.byte_sel = 1'b0;
               d.tmr = 10'h000;
               d.st = sarp_pkg::HS_RD1;
            end
            else if (q.tmr == 10'(sarp_pkg::CONV_MAX_CYC + sarp_pkg::BUSY_WAIT_CYC))
            begin
               d.err = 1'b1;
               d.st = sarp_pkg::HS_IDLE;
            end
         end
         sarp_pkg::HS_RD1:
         begin
            if (q.tmr == 10'(sarp_pkg::RD_SETTLE_CYC - 1))
            begin
               d.tmr = 10'h000;
               if (byte_mode)
               begin
                  d.result = {bus.parallel_data_pins[11:4], 4'h0};
                  d.byte_sel = 1'b1;
                  d.rd_n = ~keep_rd_low;
                  d.st = sarp_pkg::HS_RD2;
               end
               else
               begin
                  d.result = bus.parallel_data_pins;
                  d.cs_n = 1'b1;
                  d.rd_n = 1'b1;
                  d.st = sarp_pkg::HS_IDLE;
                  d.valid = (q.discard == 3'h0);
                  d.discard = (q.discard == 3'h0) ? 3'h0 : q.discard - 3'h1;
               end
            end
         end
         sarp_pkg::HS_RD2:
         begin
            d.rd_n = 1'b0;
            if (q.tmr == 10'(sarp_pkg::RD_SETTLE_CYC))
            begin
               d.result = {q.result[11:4], bus.parallel_data_pins[11:8]};
               d.cs_n = 1'b1;
               d.rd_n = 1'b1;
               d.byte_sel = 1'b0;
               d.st = sarp_pkg::HS_IDLE;
               d.valid = (q.discard == 3'h0);
               d.discard = (q.discard == 3'h0) ? 3'h0 : q.discard - 3'h1;
            end
         end
         sarp_pkg::HS_PD:
         begin
            // time the low line; saturate so a long hold never looks short
            if (q.tmr == 10'h3FF)
            begin
               d.tmr = q.tmr;
            end
            if (!pd_req)
            begin
               d.pdr_n = 1'b1;
               d.tmr = 10'h000;
               if (q.tmr < 10'(sarp_pkg::PWRDN_CYC - 1))
               begin
                  // device still in reset phase: usable at once
                  d.discard = sarp_pkg::INIT_CONV;
                  d.ready = 1'b1;
                  d.st = sarp_pkg::HS_IDLE;
               end
               else
               begin
                  d.st = sarp_pkg::HS_WAKE;
               end
            end
         end
         sarp_pkg::HS_WAKE:
         begin
            // no start before the wake delay ends
            if (q.tmr == 10'(sarp_pkg::WAKE_CYC))
            begin
               d.discard = sarp_pkg::INIT_CONV;
               d.st = sarp_pkg::HS_IDLE;
               d.ready = 1'b1;
            end
         end
      endcase
   end

   // =====================================
   // state register
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         q <= '{st: sarp_pkg::HS_RST, tmr: 10'h000, cnv_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1, byte_sel: 1'b0,
                pdr_n: 1'b0, discard: sarp_pkg::INIT_CONV, result: sarp_pkg::RESULT_RST, valid: 1'b0,
                err: 1'b0, ready: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   // =====================================
   // outputs straight from flops
   assign bus.conversion_start_n = q.cnv_n;
   assign bus.cs_n = q.cs_n;
   assign bus.rd_n = q.rd_n;
   assign bus.byte_sel = q.byte_sel;
   assign bus.powerdown_reset_n = q.pdr_n;
   assign ready = q.ready;
   assign result = q.result;
   assign result_valid = q.valid;
   assign conv_error = q.err;
endmodule : sarp_host

`default_nettype wire

// File: rtl/sarp_if.sv
// parallel readout pins joining converter and host
`default_nettype none

interface sarp_if;
   logic conversion_start_n;
   logic cs_n;
   logic rd_n;
   logic byte_sel;
   logic powerdown_reset_n;
   logic busy;
   logic [11:0] data_out;
   logic data_oe;
   wire [11:0] parallel_data_pins;

   // =====================================
   // bus level from the device enable; a released bus reads as junk (inverse of last word)
   assign parallel_data_pins = data_oe ? data_out : ~data_out;

   modport dev (
      input conversion_start_n, cs_n, rd_n, byte_sel, powerdown_reset_n,
      output busy, data_out, data_oe
   );
   modport host (
      output conversion_start_n, cs_n, rd_n, byte_sel, powerdown_reset_n,
      input busy, parallel_data_pins
   );
endinterface : sarp_if

`default_nettype wire

// File: rtl/sarp_pkg.sv
// constants, types and timing counts shared by both ends of the converter readout
`default_nettype none

package sarp_pkg;
   // =====================================
   // widths and codes
   localparam int DATA_W = 12;
   localparam logic [11:0] MARKER_CODE = 12'h0FE0;
   localparam logic [11:0] RESULT_RST = 12'h0000;
   localparam logic [2:0] INIT_CONV = 3'h4;

   // =====================================
   // times in ns, cycle counts derived from them, and fixed cycle counts
   localparam int CLK_PERIOD_NS = 4;
   localparam int CONV_TIME_NS = 200;
   localparam int CONV_MAX_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int STEP_CYC = CONV_MAX_CYC / DATA_W;
   localparam int ABORT_TIME_NS = 45;
   localparam int ABORT_MAX_CYC = ABORT_TIME_NS / CLK_PERIOD_NS;
   localparam int RST_PULSE_NS = 400;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWRDN_NS = 2000;
   localparam int PWRDN_CYC = (PWRDN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_NS = 1000;
   localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNV_LOW_CYC = 3;
   localparam int BUSY_WAIT_CYC = 8;
   localparam int RD_SETTLE_CYC = 3;

   // =====================================
   // state encodings
   typedef enum logic [2:0] {DS_ACQ, DS_CONV, DS_RST, DS_PWRDN, DS_WAKE} sarp_dstate_t;
   typedef enum logic [2:0] {HS_RST, HS_IDLE, HS_CNV, HS_BUSY, HS_RD1, HS_RD2, HS_PD, HS_WAKE} sarp_hstate_t;
endpackage : sarp_pkg

`default_nettype wire

// File: verif/sarp_asserts.sv
// link checker: timing and data relations on the readout pins
`default_nettype none

module sarp_asserts (
   input wire logic mclk,
   input wire logic rst,
   input wire logic conversion_start_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic byte_sel,
   input wire logic powerdown_reset_n,
   input wire logic busy,
   input wire logic [11:0] data_out,
   input wire logic data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CONV_CYC = 50;
   localparam int ABORT_CYC = 11;

   // =====================================
   // one clock domain
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // =====================================
   // assertions
   property p_oe;
      data_oe == $past(!cs_n && !rd_n);
   endproperty
   a_oe: assert property (p_oe) else $error("pins driven out of select and read");
   property p_start;
      $fell(conversion_start_n) && !busy && powerdown_reset_n |=> busy;
   endproperty
   a_start: assert property (p_start) else $error("busy missing after start edge");
   property p_conv_max;
      $rose(busy) |-> ##[1:CONV_CYC] !busy;
   endproperty
   a_conv_max: assert property (p_conv_max) else $error("conversion too long");
   property p_conv_min;
      $rose(busy) |-> busy [*8];
   endproperty
   a_conv_min: assert property (p_conv_min) else $error("busy dropped early");
   property p_abort;
      !powerdown_reset_n |-> ##[1:ABORT_CYC] !busy;
   endproperty
   a_abort: assert property (p_abort) else $error("conversion kept in reset");
   property p_marker;
      (!powerdown_reset_n && !byte_sel) [*3] |-> data_out == sarp_pkg::MARKER_CODE;
   endproperty
   a_marker: assert property (p_marker) else $error("no marker in reset");
   property p_low_zero;
      $past(byte_sel) |-> data_out[7:0] == 8'h00;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("low pins not zero");
   property p_hold;
      $past(!busy) && $past(powerdown_reset_n) && $past(powerdown_reset_n, 2)
         && $past({cs_n, rd_n, byte_sel}) == $past({cs_n, rd_n, byte_sel}, 2) |-> $stable(data_out);
   endproperty
   a_hold: assert property (p_hold) else $error("output changed between conversions");

   // =====================================
   // main scenarios seen
   c_conv: cover property ($rose(busy));
   c_byte: cover property (data_oe && $past(byte_sel));
   c_wake: cover property ($rose(powerdown_reset_n));
endmodule : sarp_asserts

`default_nettype wire

// File: verif/tb_top.sv
// bench: converter and host ends joined on one link
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic byte_mode = 1'b0;
   logic keep_rd_low = 1'b0;
   logic pd_req = 1'b0;
   logic [11:0] analog_in = 12'h0000;
   logic iso;
   logic pwdn;
   logic init;
   logic ready;
   logic valid;
   logic err;
   logic [11:0] result;
   logic [11:0] vals [5] = '{12'h0FFF, 12'h0800, 12'h07FF, 12'h0000, 12'h0A5C};
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;

   // =====================================
   // link and both ends
   sarp_if bus_if ();
   sarp_dev u_sarp_dev (.mclk(mclk), .rst(rst), .bus(bus_if), .analog_in(analog_in),
      .inputs_isolated(iso), .powered_down(pwdn), .initialising(init));
   sarp_host u_sarp_host (.mclk(mclk), .rst(rst), .bus(bus_if), .start(start), .byte_mode(byte_mode),
      .keep_rd_low(keep_rd_low), .pd_req(pd_req), .ready(ready), .result(result),
      .result_valid(valid), .conv_error(err));
   sarp_asserts u_sarp_asserts (.mclk(mclk), .rst(rst), .conversion_start_n(bus_if.conversion_start_n),
      .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n), .byte_sel(bus_if.byte_sel),
      .powerdown_reset_n(bus_if.powerdown_reset_n), .busy(bus_if.busy), .data_out(bus_if.data_out),
      .data_oe(bus_if.data_oe));

   // 250 MHz clock
   always #2 mclk = ~mclk;

   // =====================================
   // compare, report, finish
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   // bounded wait for host idle
   task automatic wait_rdy(input int lim);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
      chk({11'h000, ready}, 12'h0001, "ready");
   endtask : wait_rdy

   // one conversion and read; input moved while busy
   task automatic conv(input logic [11:0] v, input logic bm, input logic kr, input logic vexp);
      logic seen;
      logic bad;
      int n;
      seen = 1'b0;
      bad = 1'b0;
      analog_in = v;
      byte_mode = bm;
      keep_rd_low = kr;
      start = 1'b1;
      n = 0;
      while (ready !== 1'b0 && n < 20)
      begin
         @(negedge mclk);
         n++;
      end
      start = 1'b0;
      n = 0;
      while (ready !== 1'b1 && n < 200)
      begin
         if (bus_if.busy === 1'b1)
            analog_in = ~v;
         if (bus_if.busy === 1'b1 && iso !== 1'b1)
            bad = 1'b1;
         if (valid === 1'b1)
            seen = 1'b1;
         if (err !== 1'b0)
            bad = 1'b1;
         @(negedge mclk);
         n++;
      end
      chk({11'h000, ready}, 12'h0001, "ready after read");
      chk({11'h000, bad}, 12'h0000, "isolation or error");
      chk(result, v, "result");
      chk({11'h000, seen}, {11'h000, vexp}, "valid flag");
   endtask : conv

   // four discarded conversions, then a good one
   task automatic fresh();
      for (int i = 0; i < 4; i++)
         conv(12'h0123 + 12'(i), 1'b0, 1'b0, 1'b0);
      chk({11'h000, init}, 12'h0000, "initialising");
      conv(12'h0456, 1'b0, 1'b0, 1'b1);
   endtask : fresh

   // =====================================
   // cycle ceiling
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   // =====================================
   // main sequence
   initial
   begin
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      wait_rdy(300);
      chk({11'h000, init}, 12'h0001, "initialising");
      fresh();
      for (int i = 0; i < 5; i++)
         for (int m = 0; m < 3; m++)
            conv(vals[i], m != 0, m == 2, 1'b1);
      // short reset pulse
      pd_req = 1'b1;
      repeat (50) @(negedge mclk);
      chk({11'h000, pwdn}, 12'h0000, "short pulse powered down");
      pd_req = 1'b0;
      wait_rdy(20);
      fresh();
      // long low: powerdown and wake
      pd_req = 1'b1;
      repeat (600) @(negedge mclk);
      chk({11'h000, pwdn}, 12'h0001, "no powerdown");
      pd_req = 1'b0;
      wait_rdy(400);
      chk({11'h000, pwdn}, 12'h0000, "still waking");
      fresh();
      stop_test();
   end
endmodule : tb_top

`default_nettype wire
